/* File: rtl/capture_compare_pwm_unit.v */
// Capture/compare/PWM unit with general timer and Wishbone registers
//
// Function
// - Capture copies general timer, sets event flag
// - Prescaler cleared when off or not capture
// - Prescale change keeps counter; clear control first
// - Instruction-clocked timer holds during sleep
// - External-clocked capture works during sleep
// - Compare value checked against timer continuously
// - Match performs toggle, set, clear or trigger
// - Match sets event flag same cycle
// - Zero control write forces compare latch low
// - Mode 1010 flags only, pin released
// - Mode 1011 resets timer, starts conversion
// - Trigger immediate; timer zeroed next tick
// - Match removed before tick skips reset
// - Trigger never sets timer overflow flag
// - Compare stops during sleep
// - PWM pulse train up to ten bits
// - Mode 11xx selects PWM
// - Period rollover clears timer, sets pin unless duty zero, buffers
// - Time base equal duty clears pin
`timescale 1ns/1ps
`include "ccp_map.vh"

module capture_compare_pwm_unit (
  input  wire        clk_i,          // System clock, 250 MHz
  input  wire        rst_i,          // Synchronous reset, high
  input  wire [7:0]  adr_i,          // Wishbone byte address
  input  wire [31:0] dat_i,          // Wishbone write data
  input  wire [3:0]  sel_i,          // Wishbone byte selects
  input  wire        we_i,           // Wishbone write enable
  input  wire        cyc_i,          // Wishbone cycle
  input  wire        stb_i,          // Wishbone strobe
  output wire [31:0] dat_o,          // Wishbone read data
  output wire        ack_o,          // Wishbone acknowledge
  input  wire        pin_in_i,       // Unit pin level
  input  wire        ext_clk_i,      // External timer clock level
  input  wire        sleep_i,        // Device sleeping
  input  wire        adc_enable_i,   // Converter enabled
  output wire        pin_out_o,      // Unit pin output level
  output wire        pin_oe_o,       // Unit owns its pin
  output wire        conv_trigger_o, // Conversion start pulse
  output wire        event_flag_o    // Unit event flag
);

  // ****************************************
  // Registers and state
  // ****************************************
  reg  [5:0]  ctrl_r;      // Unit control register
  reg  [15:0] cmp_r;       // Compare value pair
  reg  [15:0] gt_r;        // General timer count
  reg  [1:0]  gtc_r;       // Timer run and source
  reg  [7:0]  prd_r;       // Period limit
  reg  [2:0]  ptc_r;       // Period timer control
  reg  [2:0]  stat_r;      // Sticky flags
  reg         ack_r;       // Bus acknowledge
  reg  [31:0] dat_r;       // Bus read data
  reg         latch_r;     // Compare output latch
  reg         pin_r;       // Pin output flop
  reg         oe_r;        // Pin ownership flop
  reg         trig_r;      // Conversion trigger flop
  reg         evt_r;       // Event flag flop
  reg         match_q_r;   // Match one cycle ago
  reg         pend_r;      // Timer reset pending
  reg  [1:0]  div_r;       // Instruction clock divider
  reg         ext_q_r;     // External clock one cycle ago

  // ****************************************
  // Decode and internal wires
  // ****************************************
  wire [3:0]  mode;        // Mode select field
  wire        is_cap;      // Capture modes
  wire        is_pwm;      // PWM modes
  wire        is_cmp;      // Compare modes
  wire        wb_go;       // New bus request
  wire        wr;          // Low byte write
  wire        insn_tick;   // Instruction clock tick
  wire        ext_tick;    // External clock rising edge
  wire        gt_tick;     // General timer advances
  wire        match;       // Timer equals compare value
  wire        cmp_hit;     // Compare match event
  wire        cap_hit;     // Capture event
  wire        trig_hit;    // Trigger mode match
  wire        pwm_pin;     // PWM level
  wire        pwm_wrap;    // Period rollover
  wire [7:0]  ptn;         // Period timer count
  wire [7:0]  duty_hi;     // Buffered duty high byte
  wire [2:0]  stat_set;    // Flag set events
  wire [2:0]  stat_clr;    // Flag clear strobes
  wire        ovf;         // Timer overflow event

  // Address compare for low-byte writes
  function wr_at;
    input        w;
    input [7:0]  a;
    input [7:0]  r;
    begin
      wr_at = w & (a == r);
    end
  endfunction

  assign mode   = ctrl_r[3:0];
  assign is_cap = (mode[3:2] == 2'b01);
  assign is_pwm = (mode[3:2] == 2'b11);
  assign is_cmp = (mode[3:2] == 2'b10) | (mode == `M_TOG);

  assign wb_go  = cyc_i & stb_i & ~ack_r;
  assign wr     = wb_go & we_i & sel_i[0];

  // ****************************************
  // General timer clocking
  // ****************************************
  // Instruction clock stops in sleep, external edges do not
  assign insn_tick = (div_r == 2'b11) & ~sleep_i;
  assign ext_tick  = ext_clk_i & ~ext_q_r;
  assign gt_tick   = gtc_r[`G_RUN] &
                     (gtc_r[`G_EXT] ? ext_tick : insn_tick);
  assign ovf       = gt_tick & ~pend_r & (gt_r == 16'hffff);

  // ****************************************
  // Compare and capture events
  // ****************************************
  // Equality is tested every cycle; the event is its onset
  assign match    = (gt_r == cmp_r);
  assign cmp_hit  = is_cmp & ~sleep_i & match & ~match_q_r;
  assign trig_hit = cmp_hit & (mode == `M_ADC);

  // Capture edge and prescaler
  capture_event u_cap (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .mode_i (mode),
    .pin_i  (pin_in_i),
    .hit_o  (cap_hit)
  );

  // Period timer and PWM level
  pwm_gen u_pwm (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (ptc_r[`F_RUN]),
    .sleep_i   (sleep_i),
    .ps_i      (ptc_r[1:0]),
    .limit_i   (prd_r),
    .duty_i    ({cmp_r[7:0], ctrl_r[`F_DLO_HI:`F_DLO_LO]}),
    .cnt_wr_i  (wr_at(wr, adr_i, `A_PTN)),
    .cnt_dat_i (dat_i[7:0]),
    .count_o   (ptn),
    .duty_hi_o (duty_hi),
    .pin_o     (pwm_pin),
    .wrap_o    (pwm_wrap)
  );

  // ****************************************
  // Sticky flags
  // ****************************************
  // Flags from hardware; a set in the clear cycle wins
  assign stat_set = {ovf, pwm_wrap & is_pwm | pwm_wrap, cap_hit | cmp_hit};
  assign stat_clr = wr_at(wr, adr_i, `A_STAT) ? dat_i[2:0] : 3'b000;

  always @(posedge clk_i)
  begin
    if (rst_i)
      stat_r <= 3'b000;
    else
      stat_r <= (stat_r & ~stat_clr) | stat_set;
  end

  // ****************************************
  // Control and configuration registers
  // ****************************************
  // Software-written registers, low byte lane only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `RST_CTRL;
      gtc_r  <= 2'b00;
      prd_r  <= `RST_PRD;
      ptc_r  <= 3'b000;
    end
    else
    begin
      // Prescale change needs no special path
      if (wr_at(wr, adr_i, `A_CTRL))
        ctrl_r <= dat_i[5:0];
      if (wr_at(wr, adr_i, `A_GTC))
        gtc_r <= dat_i[1:0];
      if (wr_at(wr, adr_i, `A_PRD))
        prd_r <= dat_i[7:0];
      if (wr_at(wr, adr_i, `A_PTC))
        ptc_r <= dat_i[2:0];
    end
  end

  // ****************************************
  // Compare value pair
  // ****************************************
  // Capture overwrites any unread value
  always @(posedge clk_i)
  begin
    if (rst_i)
      cmp_r <= `RST_16;
    else if (cap_hit)
      cmp_r <= gt_r;
    else
    begin
      if (wr_at(wr, adr_i, `A_CMPL))
        cmp_r[7:0] <= dat_i[7:0];
      // High byte is read-only while in PWM
      if (wr_at(wr, adr_i, `A_CMPH) && !is_pwm)
        cmp_r[15:8] <= dat_i[7:0];
    end
  end

  // ****************************************
  // General timer
  // ****************************************
  // Trigger reset waits for the next timer tick
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gt_r    <= `RST_16;
      div_r   <= 2'b00;
      ext_q_r <= 1'b0;
      pend_r  <= 1'b0;
    end
    else
    begin
      ext_q_r <= ext_clk_i;
      if (!sleep_i)
        div_r <= div_r + 2'b01;
      // Pending reset drops if match lost or mode left
      if (trig_hit)
        pend_r <= 1'b1;
      else if (gt_tick || !match || mode != `M_ADC)
        pend_r <= 1'b0;
      if (wr_at(wr, adr_i, `A_GTL))
        gt_r[7:0] <= dat_i[7:0];
      else if (wr_at(wr, adr_i, `A_GTH))
        gt_r[15:8] <= dat_i[7:0];
      else if (gt_tick && pend_r && match && mode == `M_ADC)
        gt_r <= `RST_16;
      else if (gt_tick)
        gt_r <= gt_r + 16'h0001;
    end
  end

  // ****************************************
  // Compare output latch and pin
  // ****************************************
  // Latch follows the match action; zero control clears it
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_r   <= 1'b0;
      match_q_r <= 1'b0;
      trig_r    <= 1'b0;
    end
    else
    begin
      match_q_r <= match;
      if (wr_at(wr, adr_i, `A_CTRL) && dat_i[5:0] == `RST_CTRL)
        latch_r <= 1'b0;
      else if (cmp_hit)
      begin
        case (mode)
          `M_TOG:  latch_r <= ~latch_r;
          `M_SET:  latch_r <= 1'b1;
          `M_CLR:  latch_r <= 1'b0;
          default: latch_r <= latch_r;
        endcase
      end
      // Trigger skips the overflow flag path entirely
      trig_r <= trig_hit & adc_enable_i;
    end
  end

  // ****************************************
  // Output flops
  // ****************************************
  // Pin owned in PWM and pin-driving compare modes only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_r <= 1'b0;
      oe_r  <= 1'b0;
      evt_r <= 1'b0;
    end
    else
    begin
      pin_r <= is_pwm ? pwm_pin : latch_r;
      oe_r  <= is_pwm |
               (is_cmp & mode != `M_SWI & mode != `M_ADC);
      evt_r <= stat_r[`S_EVT];
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One wait state; unmapped reads return zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= wb_go;
      if (wb_go && !we_i)
      begin
        case (adr_i)
          `A_CTRL: dat_r <= {26'h0000000, ctrl_r};
          `A_CMPL: dat_r <= {24'h000000, cmp_r[7:0]};
          `A_CMPH: dat_r <= {24'h000000, is_pwm ? duty_hi : cmp_r[15:8]};
          `A_GTL:  dat_r <= {24'h000000, gt_r[7:0]};
          `A_GTH:  dat_r <= {24'h000000, gt_r[15:8]};
          `A_PRD:  dat_r <= {24'h000000, prd_r};
          `A_PTC:  dat_r <= {29'h00000000, ptc_r};
          `A_PTN:  dat_r <= {24'h000000, ptn};
          `A_STAT: dat_r <= {29'h00000000, stat_r};
          `A_GTC:  dat_r <= {30'h00000000, gtc_r};
          default: dat_r <= 32'h00000000;
        endcase
      end
      else
        dat_r <= 32'h00000000;
    end
  end

  assign dat_o          = dat_r;
  assign ack_o          = ack_r;
  assign pin_out_o      = pin_r;
  assign pin_oe_o       = oe_r;
  assign conv_trigger_o = trig_r;
  assign event_flag_o   = evt_r;

endmodule // capture_compare_pwm_unit

/* File: inc/ccp_map.vh */
// Register offsets, field positions, mode codes and reset values of the unit
`ifndef CCP_MAP_VH
`define CCP_MAP_VH

// Register byte offsets on the bus
`define A_CTRL  8'h00
`define A_CMPL  8'h04
`define A_CMPH  8'h08
`define A_GTL   8'h0c
`define A_GTH   8'h10
`define A_PRD   8'h14
`define A_PTC   8'h18
`define A_PTN   8'h1c
`define A_STAT  8'h20
`define A_GTC   8'h24

// Mode select field codes
`define M_OFF   4'h0
`define M_TOG   4'h2
`define M_CFALL 4'h4
`define M_CRISE 4'h5
`define M_CR4   4'h6
`define M_CR16  4'h7
`define M_SET   4'h8
`define M_CLR   4'h9
`define M_SWI   4'ha
`define M_ADC   4'hb

// Field positions
`define F_DLO_HI   5
`define F_DLO_LO   4
`define F_RUN      2
`define S_EVT      0
`define S_PTF      1
`define S_OVF      2
`define G_RUN      0
`define G_EXT      1

// Reset values
`define RST_CTRL   6'h00
`define RST_PRD    8'hff
`define RST_16     16'h0000

// Capture prescale terminal counts
`define CAP_LAST4  4'h3
`define CAP_LAST16 4'hf

`endif

/* File: rtl/capture_event.v */
// Capture pin edge detector and capture prescaler
`timescale 1ns/1ps
`include "ccp_map.vh"

module capture_event (
  input  wire       clk_i,   // System clock
  input  wire       rst_i,   // Synchronous reset
  input  wire [3:0] mode_i,  // Mode select field
  input  wire       pin_i,   // Unit pin level
  output wire       hit_o    // Capture event this cycle
);

  reg       pin_q_r;  // Pin one cycle ago
  reg [3:0] pre_r;    // Prescaler counter
  wire      rise;     // Rising edge
  wire      fall;     // Falling edge
  wire      is_cap;   // Capture mode active

  assign rise   = pin_i & ~pin_q_r;
  assign fall   = ~pin_i & pin_q_r;
  assign is_cap = (mode_i[3:2] == 2'b01);

  // Event selection per capture mode
  assign hit_o = (mode_i == `M_CFALL) ? fall :
                 (mode_i == `M_CRISE) ? rise :
                 (mode_i == `M_CR4)   ? (rise & (pre_r[1:0] == `CAP_LAST4 >> 0)) :
                 (mode_i == `M_CR16)  ? (rise & (pre_r == `CAP_LAST16)) :
                 1'b0;

  // Edge memory and prescaler; prescaler cleared when off or not capturing
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_q_r <= 1'b0;
      pre_r   <= 4'h0;
    end
    else
    begin
      pin_q_r <= pin_i;
      if (!is_cap)
        pre_r <= 4'h0;
      else if (rise)
        pre_r <= pre_r + 4'h1;
    end
  end

endmodule // capture_event

/* File: rtl/pwm_gen.v */
// Period timer, duty double buffer and PWM pin generator
`timescale 1ns/1ps
`include "ccp_map.vh"

module pwm_gen (
  input  wire       clk_i,      // System clock
  input  wire       rst_i,      // Synchronous reset
  input  wire       run_i,      // Period timer run
  input  wire       sleep_i,    // Sleep holds the timer
  input  wire [1:0] ps_i,       // Period timer prescale
  input  wire [7:0] limit_i,    // Period limit
  input  wire [9:0] duty_i,     // Duty high byte and low bits
  input  wire       cnt_wr_i,   // Software load of count
  input  wire [7:0] cnt_dat_i,  // Value loaded
  output wire [7:0] count_o,    // Period timer count
  output wire [7:0] duty_hi_o,  // Buffered duty high byte
  output wire       pin_o,      // PWM level
  output wire       wrap_o      // Period rollover pulse
);

  reg  [7:0] pre_r;   // Fosc prescaler
  reg  [7:0] tmr_r;   // Period timer count
  reg  [9:0] dbuf_r;  // Duty buffer
  reg        pin_r;   // PWM level
  wire       go;      // Timer advancing
  wire       step;    // Count increments
  wire [9:0] base;    // 10-bit time base

  // Last prescaler value for each setting: 4, 16, 64, 256 clocks
  function [7:0] last_of;
    input [1:0] ps;
    begin
      case (ps)
        2'd0:    last_of = 8'h03;
        2'd1:    last_of = 8'h0f;
        2'd2:    last_of = 8'h3f;
        default: last_of = 8'hff;
      endcase
    end
  endfunction

  // Two top prescaler bits extend the count
  function [1:0] low_of;
    input [1:0] ps;
    input [7:0] pre;
    begin
      case (ps)
        2'd0:    low_of = pre[1:0];
        2'd1:    low_of = pre[3:2];
        2'd2:    low_of = pre[5:4];
        default: low_of = pre[7:6];
      endcase
    end
  endfunction

  assign go        = run_i & ~sleep_i;
  assign step      = go & (pre_r == last_of(ps_i));
  assign base      = {tmr_r, low_of(ps_i, pre_r)};
  assign wrap_o    = step & (tmr_r == limit_i);
  assign count_o   = tmr_r;
  assign duty_hi_o = dbuf_r[9:2];
  assign pin_o     = pin_r;

  // Timer, duty buffer and pin
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r  <= 8'h00;
      tmr_r  <= 8'h00;
      dbuf_r <= 10'h000;
      pin_r  <= 1'b0;
    end
    else
    begin
      if (go)
        pre_r <= step ? 8'h00 : pre_r + 8'h01;
      if (cnt_wr_i)
        tmr_r <= cnt_dat_i;
      else if (wrap_o)
        tmr_r <= 8'h00;
      else if (step)
        tmr_r <= tmr_r + 8'h01;
      if (wrap_o)
      begin
        dbuf_r <= duty_i;
        pin_r  <= (duty_i != 10'h000);
      end
      else if (go && base == dbuf_r)
        pin_r <= 1'b0;
    end
  end

endmodule // pwm_gen

/* File: test/ccp_monitor.sv */
// Port checker of the capture/compare/PWM unit
`timescale 1ns/1ps
`include "ccp_map.vh"

module ccp_monitor (
  input wire        clk_i,          // System clock
  input wire        rst_i,          // Reset
  input wire [7:0]  adr_i,          // Bus address
  input wire [31:0] dat_i,          // Bus write data
  input wire [3:0]  sel_i,          // Byte selects
  input wire        we_i,           // Write enable
  input wire        cyc_i,          // Bus cycle
  input wire        stb_i,          // Bus strobe
  input wire [31:0] dat_o,          // Read data
  input wire        ack_o,          // Acknowledge
  input wire        pin_in_i,       // Pin level
  input wire        ext_clk_i,      // External timer clock
  input wire        sleep_i,        // Sleep
  input wire        adc_enable_i,   // Converter enabled
  input wire        pin_out_o,      // Pin output level
  input wire        pin_oe_o,       // Pin owned
  input wire        conv_trigger_o, // Conversion start
  input wire        event_flag_o    // Event flag
);
  // ************************************
  // Helper state
  // ************************************
  reg  [3:0] mode_r;   // Mode as last written
  reg  [2:0] since_r;  // Cycles since control write
  wire       taken;    // Request taken
  wire       ctrl_wr;  // Control write accepted
  wire       evt_clr;  // Event flag clear accepted
  wire       owns;     // Mode drives the pin
  assign taken   = cyc_i & stb_i & ~ack_o;
  assign ctrl_wr = taken & we_i & sel_i[0] & (adr_i == `A_CTRL);
  assign evt_clr = taken & we_i & sel_i[0] & (adr_i == `A_STAT) & dat_i[`S_EVT];
  assign owns    = (mode_r == `M_TOG) | (mode_r[3:1] == 3'b100) | (&mode_r[3:2]);
  // Track mode writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r  <= 4'h0;
      since_r <= 3'h7;
    end
    else if (ctrl_wr)
    begin
      mode_r  <= dat_i[3:0];
      since_r <= 3'h0;
    end
    else if (since_r != 3'h7)
      since_r <= since_r + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence cap_rise;
    (mode_r == `M_CRISE) && (since_r == 3'h7) ##0 $rose(pin_in_i);
  endsequence
  ack_answer_a: assert property (bus_req |=> ack_o ##1 !ack_o)
    else $error("ack not one pulse");
  idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("data outside ack");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !pin_oe_o && !pin_out_o
    && !conv_trigger_o && !event_flag_o && !ack_o) else $error("busy after reset");
  capture_flag_a: assert property (cap_rise |-> ##[1:4] event_flag_o)
    else $error("capture no flag");
  trig_flag_a: assert property (conv_trigger_o |=> event_flag_o)
    else $error("trigger no flag");
  trig_pulse_a: assert property (conv_trigger_o |=> !conv_trigger_o)
    else $error("long trigger");
  trig_gate_a: assert property (conv_trigger_o |-> $past(adc_enable_i))
    else $error("trigger ungated");
  pin_owner_a: assert property (since_r == 3'h7 |-> pin_oe_o == owns)
    else $error("wrong pin owner");
  latch_clear_a: assert property (ctrl_wr && dat_i[7:0] == 8'h00 |-> ##[1:3] (!pin_out_o) [*4])
    else $error("latch not cleared");
  flag_sticky_a: assert property ($fell(event_flag_o) |-> $past(evt_clr, 2) || $past(evt_clr, 3))
    else $error("flag lost");
endmodule // ccp_monitor

bind capture_compare_pwm_unit ccp_monitor ccp_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .pin_in_i(pin_in_i), .ext_clk_i(ext_clk_i),
  .sleep_i(sleep_i), .adc_enable_i(adc_enable_i), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .conv_trigger_o(conv_trigger_o), .event_flag_o(event_flag_o));

/* File: test/pin_partner.sv */
// Board side: unit pin and external clock
`timescale 1ns/1ps

module pin_partner (
  input  wire  clk_i,      // System clock
  input  wire  pin_out_i,  // Unit output level
  input  wire  pin_oe_i,   // Unit owns the pin
  input  wire  drive_i,    // Level applied from outside
  input  wire  ext_run_i,  // External clock source running
  output wire  pin_o,      // Level seen on the pin
  output wire  ext_clk_o   // External timer clock
);
  // ************************************
  // Pin and clock source
  // ************************************
  reg [1:0] div_r = 2'h0;  // External clock divider
  reg       clk_r = 1'b0;  // External clock, still when stopped
  // Unit drives while it owns the pin
  assign pin_o     = pin_oe_i ? pin_out_i : drive_i;
  assign ext_clk_o = clk_r;
  // Clock in step with system clock, stops low
  always @(posedge clk_i)
  begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3)
      clk_r <= ext_run_i & ~clk_r;
  end
endmodule // pin_partner

/* File: test/capture_compare_pwm_unit_bench.sv */
// Bench of the capture/compare/PWM unit
`timescale 1ns/1ps
`include "ccp_map.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module capture_compare_pwm_unit_bench;
  // ************************************
  // Signals and helpers
  // ************************************
  logic        clk_i = 1'b0, rst_i = 1'b1;            // Clock and reset
  logic [7:0]  adr = 8'h00, r, lim;                   // Address, read byte, period
  logic [31:0] dat = 32'h0;                           // Write data
  logic [3:0]  sel = 4'h0;                            // Byte selects
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, p;  // Bus strobes, latch model
  logic        drive = 1'b0, ext_run = 1'b0, sleep = 1'b0, adc_en = 1'b0;
  logic [15:0] v;                                     // Random timer value
  logic [9:0]  duty;                                  // PWM duty
  logic [3:0]  modes [0:5] = '{`M_SET, `M_TOG, `M_TOG, `M_CLR, `M_SWI, `M_SET};
  wire  [31:0] rdat;
  wire         ack, pin, ext_clk, pin_out, pin_oe, trig, flag;
  integer      err_total = 0, num_checks = 0, seed = 7, i, n, hi;
  capture_compare_pwm_unit capture_compare_pwm_unit_inst (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr), .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
    .dat_o(rdat), .ack_o(ack), .pin_in_i(pin), .ext_clk_i(ext_clk), .sleep_i(sleep),
    .adc_enable_i(adc_en), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .conv_trigger_o(trig), .event_flag_o(flag));
  pin_partner pin_partner_inst (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .drive_i(drive), .ext_run_i(ext_run), .pin_o(pin), .ext_clk_o(ext_clk));
  // Free running clock
  initial
    forever #2 clk_i = ~clk_i;
  task waitc(input integer c);
    repeat (c) @(negedge clk_i);
  endtask
  // One bus cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    integer k;
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h0, d};
      sel <= 4'h1;
      for (k = 0; ack !== 1'b1 && k < 20; k++)
        @(negedge clk_i);
      r = rdat[7:0];
      if (k >= 20)
        err_total++;
      @(posedge clk_i);
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 8'h00);
  endtask
  task gt_set(input logic [15:0] t);
    wr(`A_GTH, t[15:8]);
    wr(`A_GTL, t[7:0]);
  endtask
  // Pin pulses, three clocks high and low
  task pulses(input integer c);
    repeat (c)
    begin
      drive <= 1'b1;
      repeat (3) @(posedge clk_i);
      drive <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  function automatic logic owns(input logic [3:0] m);
    owns = (m == `M_TOG) || (m == `M_SET) || (m == `M_CLR) || (m[3:2] == 2'b11);
  endfunction
  function automatic integer pwm_high(input logic [9:0] d, input logic [7:0] l);
    pwm_high = (d == 10'h000) ? 0 : (d >= 4 * (l + 1)) ? 4 * (l + 1) : d + 1;
  endfunction
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short
  initial
  begin
    #400000;
    err_total++;
    conclude;
  end
  // ************************************
  // Main sequence
  // ************************************
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`A_CTRL);
    `CHK("ctrl reset", 8'h00, r)
    rd(`A_PRD);
    `CHK("limit reset", 8'hff, r)
    wr(8'h3c, 8'h5a);
    rd(8'h3c);
    `CHK("unmapped", 8'h00, r)
    // Capture modes
    for (i = 0; i < 4; i++)
    begin
      n = (i < 2) ? 1 : (i == 2) ? 4 : 16;
      v = $random(seed);
      wr(`A_CTRL, 8'h00);
      wr(`A_CTRL, {4'h0, `M_CFALL + i[3:0]});
      wr(`A_STAT, 8'h01);
      gt_set(v);
      pulses(n - 1);
      waitc(3);
      `CHK("early flag", 1'b0, flag)
      pulses(1);
      waitc(3);
      `CHK("capture flag", 1'b1, flag)
      rd(`A_CMPL);
      `CHK("capture low", v[7:0], r)
      rd(`A_CMPH);
      `CHK("capture high", v[15:8], r)
    end
    // Off clears a partial prescale
    wr(`A_CTRL, {4'h0, `M_CR4});
    pulses(3);
    wr(`A_CTRL, 8'h00);
    wr(`A_CTRL, {4'h0, `M_CR4});
    wr(`A_STAT, 8'h01);
    v = $random(seed);
    gt_set(v);
    pulses(3);
    waitc(3);
    `CHK("prescale cleared", 1'b0, flag)
    pulses(1);
    rd(`A_CMPL);
    `CHK("overwritten", v[7:0], r)
    // Sleep capture, external clock
    wr(`A_GTC, 8'h03);
    ext_run <= 1'b1;
    sleep <= 1'b1;
    wr(`A_CTRL, {4'h0, `M_CRISE});
    wr(`A_STAT, 8'h01);
    pulses(1);
    waitc(3);
    `CHK("sleep capture", 1'b1, flag)
    ext_run <= 1'b0;
    // Timer holds in sleep
    wr(`A_GTC, 8'h01);
    waitc(2);
    rd(`A_GTL);
    v[7:0] = r;
    waitc(40);
    rd(`A_GTL);
    `CHK("held", v[7:0], r)
    sleep <= 1'b0;
    waitc(40);
    rd(`A_GTL);
    `CHK("resumed", 1'b1, r != v[7:0])
    // Compare actions, timer written to match
    wr(`A_GTC, 8'h00);
    p = 1'b0;
    for (i = 0; i < 6; i++)
    begin
      v = $random(seed);
      wr(`A_CMPL, v[7:0]);
      wr(`A_CMPH, v[15:8]);
      gt_set(~v);
      wr(`A_CTRL, {4'h0, modes[i]});
      wr(`A_STAT, 8'h01);
      gt_set(v);
      waitc(4);
      p = (modes[i] == `M_SET) ? 1'b1 : (modes[i] == `M_CLR) ? 1'b0 :
          (modes[i] == `M_TOG) ? ~p : p;
      `CHK("match flag", 1'b1, flag)
      `CHK("pin owner", owns(modes[i]), pin_oe)
      if (owns(modes[i]))
        `CHK("pin level", p, pin_out)
    end
    wr(`A_CTRL, 8'h00);
    waitc(3);
    `CHK("latch cleared", 1'b0, pin_out)
    // Trigger mode with the timer running
    wr(`A_CMPL, 8'h40);
    wr(`A_CMPH, 8'h00);
    gt_set(16'h0000);
    adc_en <= 1'b1;
    wr(`A_CTRL, {4'h0, `M_ADC});
    wr(`A_STAT, 8'h07);
    wr(`A_GTC, 8'h01);
    n = 0;
    while (trig !== 1'b1 && n < 1000)
    begin
      waitc(1);
      n++;
    end
    `CHK("trigger", 1'b1, trig)
    waitc(8);
    rd(`A_GTL);
    `CHK("timer restarted", 1'b1, r < 8'h10)
    rd(`A_STAT);
    `CHK("no overflow", 1'b0, r[`S_OVF])
    adc_en <= 1'b0;
    wr(`A_STAT, 8'h01);
    hi = 0;
    repeat (400)
    begin
      waitc(1);
      hi = hi + (trig === 1'b1);
    end
    `CHK("gated trigger", 0, hi)
    `CHK("gated flag", 1'b1, flag)
    // No compare while sleeping
    wr(`A_GTC, 8'h00);
    sleep <= 1'b1;
    wr(`A_CTRL, {4'h0, `M_SWI});
    gt_set(16'h0000);
    wr(`A_STAT, 8'h01);
    gt_set(16'h0040);
    waitc(4);
    `CHK("sleep compare", 1'b0, flag)
    sleep <= 1'b0;
    // PWM: zero, random and oversized duty
    for (i = 0; i < 3; i++)
    begin
      lim = 8'h03 + ($random(seed) & 8'h0c);
      duty = (i == 0) ? 10'h000 : (i == 2) ? 10'h3ff : $unsigned($random(seed)) % (4 * lim + 5);
      wr(`A_CTRL, 8'h00);
      wr(`A_PRD, lim);
      wr(`A_CTRL, {2'b00, duty[1:0], 4'hc});
      wr(`A_CMPL, duty[9:2]);
      wr(`A_STAT, 8'h02);
      wr(`A_PTC, 8'h04);
      waitc(12 * (lim + 1));
      hi = 0;
      repeat (8 * (lim + 1))
      begin
        waitc(1);
        hi = hi + (pin === 1'b1);
      end
      `CHK("pwm high", 2 * pwm_high(duty, lim), hi)
      rd(`A_STAT);
      `CHK("period flag", 1'b1, r[`S_PTF])
      wr(`A_PTC, 8'h00);
    end
    conclude;
  end
endmodule // capture_compare_pwm_unit_bench
